// File: design/cspg_top.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cspg_top #(
    parameter bit STRICT_OE = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic supply_good_input,
    input wire logic card_present_1_n,
    input wire logic card_present_2_n,
    output cspg_pkg::cspg_switch_t supply_switch,
    output logic socket_drive_en,
    output logic card_reset_drive_en,
    output logic card_power_on
);

    ////////////////////////////////////////////////////////////////////////
    // register bus

    // word match of a byte address against a register index
    function automatic logic cspg_hit(input logic [7:0] addr,
                                      input logic [5:0] idx);
        cspg_hit = (addr[7:2] == idx);
    endfunction

    cspg_pkg::cspg_bus_state_t bus_state_reg;
    cspg_pkg::cspg_bus_state_t bus_state_next;
    logic waitreq_reg;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic [7:0] power_reg;
    logic [7:0] supply_reg;
    logic [7:0] status_word;
    logic req;
    logic take;
    logic hit_power;
    logic hit_supply;
    logic hit_status;
    logic wr_power;
    logic wr_supply;

    // a request is answered one cycle after it is first seen
    assign req = avs_read | avs_write;
    assign take = (bus_state_reg == cspg_pkg::CSPG_BUS_ANSWER) & req;
    assign bus_state_next = (bus_state_reg == cspg_pkg::CSPG_BUS_IDLE && req)
                          ? cspg_pkg::CSPG_BUS_ANSWER
                          : cspg_pkg::CSPG_BUS_IDLE;

    // address decode
    assign hit_power = cspg_hit(avs_address, cspg_pkg::IDX_POWER);
    assign hit_supply = cspg_hit(avs_address, cspg_pkg::IDX_SUPPLY);
    assign hit_status = cspg_hit(avs_address, cspg_pkg::IDX_STATUS);

    // writes land on the edge where waitrequest is seen low, lane 0 only
    assign wr_power = take & avs_write & hit_power & avs_byteenable[0];
    assign wr_supply = take & avs_write & hit_supply & avs_byteenable[0];

    // read mux; unmapped addresses read zero
    always_comb begin
        readdata_next = 32'h0000_0000;
        if (hit_power) begin
            readdata_next[7:0] = power_reg;
        end else if (hit_supply) begin
            readdata_next[7:0] = supply_reg;
        end else if (hit_status) begin
            readdata_next[7:0] = status_word;
        end
    end

    // handshake flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= cspg_pkg::CSPG_BUS_IDLE;
            waitreq_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            bus_state_reg <= bus_state_next;
            waitreq_reg <= (bus_state_next != cspg_pkg::CSPG_BUS_ANSWER);
            if (bus_state_next == cspg_pkg::CSPG_BUS_ANSWER) begin
                readdata_reg <= readdata_next;
            end
        end
    end

    // software registers, all fields plain storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_reg <= cspg_pkg::RST_POWER;
            supply_reg <= cspg_pkg::RST_SUPPLY;
        end else if (ce) begin
            if (wr_power) begin
                power_reg <= avs_writedata[7:0];
            end
            if (wr_supply) begin
                supply_reg <= avs_writedata[7:0];
            end
        end
    end

    assign avs_waitrequest = waitreq_reg;
    assign avs_readdata = readdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // power and output gating

    logic vcc_power;
    logic auto_power;
    logic card_enable;
    logic sel_3v;
    logic [1:0] vpp_code;
    logic card_in;
    logic power_active;
    logic drive_ok;
    cspg_pkg::cspg_switch_t switch_next;
    cspg_pkg::cspg_switch_t switch_reg;
    logic drive_reg;
    logic power_on_reg;

    assign vcc_power = power_reg[cspg_pkg::POS_VCC_POWER];
    assign auto_power = power_reg[cspg_pkg::POS_AUTO_POWER];
    assign card_enable = power_reg[cspg_pkg::POS_CARD_ENABLE];
    assign sel_3v = supply_reg[cspg_pkg::POS_SEL_3V];
    assign vpp_code = power_reg[cspg_pkg::POS_VPP_HI:cspg_pkg::POS_VPP_LO];

    // only both detects low means a fully seated card
    assign card_in = ~card_present_1_n & ~card_present_2_n;

    // activation: supply good, vcc power, and auto-power satisfied
    assign power_active = supply_good_input & vcc_power
                        & (~auto_power | card_in);

    // output enable; strict variant also needs vcc power
    assign drive_ok = supply_good_input & card_in & card_enable
                    & (~STRICT_OE | vcc_power);

    // switch levels; everything inactive unless activated
    always_comb begin
        switch_next = cspg_pkg::SWITCH_OFF;
        if (power_active) begin
            switch_next.vcc_3v_switch_n = ~sel_3v;
            switch_next.vcc_5v_switch_n = sel_3v;
            case (vpp_code)
                cspg_pkg::VPP_FOLLOW: begin
                    switch_next.vpp_follow_supply_switch = 1'b1;
                end
                cspg_pkg::VPP_PROGRAM: begin
                    switch_next.vpp_program_switch = 1'b1;
                end
                default: begin
                    switch_next.vpp_program_switch = 1'b0;
                end
            endcase
        end
    end

    // registered pin drivers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switch_reg <= cspg_pkg::SWITCH_OFF;
            drive_reg <= 1'b0;
            power_on_reg <= 1'b0;
        end else if (ce) begin
            switch_reg <= switch_next;
            drive_reg <= drive_ok;
            power_on_reg <= power_active;
        end
    end

    assign status_word = {1'b0, power_on_reg, 2'h0, card_in, card_in, 2'h0};
    assign supply_switch = switch_reg;
    // one enable covers strobes, selects, address, data and card reset
    assign socket_drive_en = drive_reg;
    assign card_reset_drive_en = drive_reg;
    assign card_power_on = power_on_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    vcc_off_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !vcc_power |=> supply_switch.vcc_3v_switch_n
            && supply_switch.vcc_5v_switch_n)
        else $error("vcc switch active while vcc power clear");

    no_good_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !supply_good_input |=> supply_switch == cspg_pkg::SWITCH_OFF)
        else $error("switches active without supply good");

    vcc_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && power_active |=> supply_switch.vcc_3v_switch_n
            == !$past(sel_3v) && supply_switch.vcc_5v_switch_n
            == $past(sel_3v))
        else $error("wrong vcc switch selected");

    auto_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && auto_power && (card_present_1_n || card_present_2_n)
        |=> !card_power_on && supply_switch == cspg_pkg::SWITCH_OFF)
        else $error("auto-power on without card");

    manual_power_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !auto_power && vcc_power && supply_good_input
        |=> card_power_on)
        else $error("manual power ignored");

    vpp_program_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && power_active && vpp_code == cspg_pkg::VPP_PROGRAM
        |=> supply_switch.vpp_program_switch
            && !supply_switch.vpp_follow_supply_switch)
        else $error("program code not applied");

    vpp_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (!power_active || vpp_code == cspg_pkg::VPP_ZERO_ALT)
        |=> !supply_switch.vpp_program_switch
            && !supply_switch.vpp_follow_supply_switch)
        else $error("vpp driven when it must be off");

    float_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (!supply_good_input || !card_enable || !card_in)
        |=> !socket_drive_en && !card_reset_drive_en)
        else $error("socket driven while it must float");

    drive_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !STRICT_OE && supply_good_input && card_in && card_enable
        |=> socket_drive_en)
        else $error("socket not driven");

    write_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wr_power |=> power_reg == $past(avs_writedata[7:0]))
        else $error("power register write lost");

    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

endmodule
`default_nettype wire

// File: shared/cspg_pkg.sv
package cspg_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_POWER = 6'h02;
    localparam logic [5:0] IDX_SUPPLY = 6'h16;

    // power control field positions
    localparam int POS_VPP_LO = 0;
    localparam int POS_VPP_HI = 1;
    localparam int POS_COMPAT_LO = 2;
    localparam int POS_COMPAT_HI = 3;
    localparam int POS_VCC_POWER = 4;
    localparam int POS_AUTO_POWER = 5;
    localparam int POS_COMPAT_6 = 6;
    localparam int POS_CARD_ENABLE = 7;

    // supply select field: 1 picks the 3.3 V switch, 0 the 5 V one
    localparam int POS_SEL_3V = 1;

    // status field positions
    localparam int POS_ST_DET1 = 2;
    localparam int POS_ST_DET2 = 3;
    localparam int POS_ST_POWER_ON = 6;

    // reset values
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_SUPPLY = 8'h00;

    // vpp field codes
    localparam logic [1:0] VPP_ZERO = 2'h0;
    localparam logic [1:0] VPP_FOLLOW = 2'h1;
    localparam logic [1:0] VPP_PROGRAM = 2'h2;
    localparam logic [1:0] VPP_ZERO_ALT = 2'h3;

    // bus handshake states
    typedef enum logic {
        CSPG_BUS_IDLE,
        CSPG_BUS_ANSWER
    } cspg_bus_state_t;

    // external power switch controls
    typedef struct packed {
        logic vcc_3v_switch_n;
        logic vcc_5v_switch_n;
        logic vpp_program_switch;
        logic vpp_follow_supply_switch;
    } cspg_switch_t;

    localparam cspg_switch_t SWITCH_OFF = 4'hc;

endpackage

// File: verification/card_socket_power_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module card_socket_power_gating_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [1:0] seat = 2'h0;
    logic supply_ok = 1'b0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest;
    wire logic supply_good_input;
    wire logic card_present_1_n;
    wire logic card_present_2_n;
    cspg_pkg::cspg_switch_t supply_switch;
    wire logic socket_drive_en;
    wire logic card_reset_drive_en;
    wire logic card_power_on;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int p;
    int s;
    logic [5:0] e;
    logic [31:0] q;
    logic [31:0] st;

    cspg_top dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .supply_good_input(supply_good_input),
        .card_present_1_n(card_present_1_n),
        .card_present_2_n(card_present_2_n),
        .supply_switch(supply_switch), .socket_drive_en(socket_drive_en),
        .card_reset_drive_en(card_reset_drive_en),
        .card_power_on(card_power_on));
    cspg_socket_model socket (.clk(clk), .seat(seat), .supply_ok(supply_ok),
        .supply_good_input(supply_good_input),
        .card_present_1_n(card_present_1_n),
        .card_present_2_n(card_present_2_n));

    ////////////////////////////////////////////////////////////////////
    // clock and run limit
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(logic wr, logic [7:0] a, logic [7:0] d, logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // only the run limit ends a wait that never answers
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // reference: {vcc3_n, vcc5_n, program, follow, drive enable, power on}
    function automatic logic [5:0] model(int p, int s, int g, int c);
        int inn;
        int act;
        inn = (c == 3);
        act = g && ((p >> 4) & 1) && (!((p >> 5) & 1) || inn);
        return {1'(!(act && s)), 1'(!(act && !s)), 1'(act && (p & 3) == 2),
            1'(act && (p & 3) == 1), 1'(g && inn && ((p >> 7) & 1)),
            1'(act)};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset, refused accesses, then every vpp code and random traffic
    initial begin
        void'($urandom(45));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("reset switch", 32'hc, 32'(supply_switch)); // idle
        bus(1'b0, 8'h08, 8'h00, 4'hf);
        check("reset power reg", 32'h0, q); // cleared
        bus(1'b1, 8'h08, 8'hff, 4'he);
        bus(1'b1, 8'h0c, 8'hff, 4'hf);
        bus(1'b0, 8'h0c, 8'h00, 4'hf);
        check("unmapped read", 32'h0, q); // hole reads zero
        bus(1'b0, 8'h08, 8'h00, 4'hf);
        check("masked write", 32'h0, q); // lane off
        for (int i = 0; i < 60; i++) begin
            p = (i < 4) ? (8'hb0 | i) : ($urandom % 256);
            s = $urandom % 2;
            seat <= (i < 4) ? 2'h3 : 2'($urandom);
            supply_ok <= (i < 4) ? 1'b1 : 1'($urandom);
            bus(1'b1, 8'h08, 8'(p), 4'h1);
            bus(1'b1, 8'h58, {6'h0, 1'(s), 1'b0}, 4'h1);
            repeat (4) @(posedge clk);
            e = model(p, s, supply_ok, seat);
            check("switch", 32'(e[5:2]), 32'(supply_switch));
            check("drive en", 32'(e[1]), 32'(socket_drive_en));
            check("reset en", 32'(e[1]), 32'(card_reset_drive_en));
            check("power on", 32'(e[0]), 32'(card_power_on));
            bus(1'b0, 8'h08, 8'h00, 4'hf);
            check("power reg", 32'(p), q); // readback
            bus(1'b0, 8'h04, 8'h00, 4'hf);
            st = {25'h0, e[0], 2'h0, {2{&seat}}, 2'h0};
            check("status", st, q & 32'h4c);
        end
        // clock enable low freezes the pin drivers
        ce <= 1'b0;
        supply_ok <= ~supply_ok;
        repeat (4) @(posedge clk);
        check("frozen switch", 32'(e[5:2]), 32'(supply_switch));
        check("frozen power on", 32'(e[0]), 32'(card_power_on));
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        e = model(p, s, supply_ok, seat);
        check("thawed switch", 32'(e[5:2]), 32'(supply_switch));
        check("thawed power on", 32'(e[0]), 32'(card_power_on));
        // second reset in mid-run clears the register again
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("rerun switch", 32'hc, 32'(supply_switch)); // idle
        bus(1'b0, 8'h08, 8'h00, 4'hf);
        check("rerun power reg", 32'h0, q); // cleared
        check("rerun power on", 32'h0, 32'(card_power_on));
        complete_run();
    end
endmodule
`default_nettype wire

// File: verification/cspg_socket_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// socket side: detect contacts pulled up while empty, supply monitor
module cspg_socket_model (
    input wire logic clk,
    input wire logic [1:0] seat,
    input wire logic supply_ok,
    output logic supply_good_input,
    output logic card_present_1_n,
    output logic card_present_2_n
);
    // empty socket and dead supply until the first edge
    initial begin
        supply_good_input = 1'b0;
        card_present_1_n = 1'b1;
        card_present_2_n = 1'b1;
    end

    // contacts settle one edge after the bench moves the card
    always @(posedge clk) begin
        card_present_1_n <= ~seat[0];
        card_present_2_n <= ~seat[1];
        supply_good_input <= supply_ok;
    end
endmodule
`default_nettype wire
